// *** plm_top.sv ***
/*
 Link supervision, speed fallback, local loopback, crossover and polarity
 report, and packet/error statistics, with an APB register slave.
 Assumes all event and symbol inputs come from logic on CLK_SYS_I.
*/
`timescale 1ns/10ps
// Functional notes
// - faster links stay up while idles/data arrive
// - send a normal link pulse every 16 ms
// - partner pulses every 8..24 ms keep link
// - drop link, stop transmit, on lost pulses/idles
// - after loss renegotiate, else NLP or MLT-3
// - repeated negotiation failure steps advertisement down
// - step gigabit to 100, then 100 to 10
// - fallback reverts on resets, silence, link drop
// - fallback runs only while its enable is set
// - flag links made through fallback
// - loopback feeds scrambler output to descrambler
// - loopback silences line, transmitters powered down
// - report crossover for both channel pairs
// - report polarity inversion per channel
// - channel 1 valid after negotiation, others link
// - 48-bit good receive packet counter, three words
// - low read snapshots mid and high
// - high read clears the whole counter; an event in that cycle leaves it at 1
// - 48-bit CRC error counter, same scheme
// - 16-bit receive error during data counter
// - 16-bit receive error during idle counter
// - 48-bit transmit packet counter, same scheme
// - link state shown in status and LEDs
module plm_top #(
    parameter int CYC_PER_MS = plm_pkg::CYC_PER_MS,
    parameter int AN_TRIES = plm_pkg::AN_TRIES
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    input wire plm_pkg::plm_apb_req_t APB_I,
    output plm_pkg::plm_apb_rsp_t APB_O,
    input wire plm_pkg::plm_ev_t EV_I,
    input wire logic AN_DONE_I,
    input wire logic [1:0] AN_SPD_I,
    input wire plm_pkg::plm_mdi_t MDI_I,
    input wire logic [plm_pkg::SYM_W-1:0] SCR_OUT_I,
    input wire logic [plm_pkg::SYM_W-1:0] LINE_RX_I,
    output logic [plm_pkg::SYM_W-1:0] LINE_TX_O,
    output logic [plm_pkg::SYM_W-1:0] DESCR_IN_O,
    output logic TX_PWR_EN_O,
    output logic TX_EN_O,
    output logic LINK_UP_O,
    output logic NLP_TX_O,
    output logic FLP_TX_O,
    output logic MLT3_TX_O,
    output logic AN_RESTART_O,
    output logic [2:0] ADV_O,
    output logic [2:0] LED_O
);
    import plm_pkg::*;

    plm_st_t s;
    plm_st_t n;
    logic [1:0] spd_eff;
    logic fail;
    logic hit;
    logic sw;
    logic acc;
    logic [2:0] inc48;
    logic [1:0] inc16;
    logic [31:0] stat_now;

    function automatic logic [MS_W-1:0] ms_inc(input logic [MS_W-1:0] v);
        ms_inc = (v == {MS_W{1'b1}}) ? v : v + 12'h001;
    endfunction : ms_inc

    function automatic logic [2:0] adv_step(input logic [2:0] a);
        if (a[2] && (a[1:0] != 2'h0)) begin
            adv_step = {1'b0, a[1:0]};
        end else if (a[1] && a[0]) begin
            adv_step = 3'h1;
        end else begin
            adv_step = a;
        end
    endfunction : adv_step

    function automatic logic [2:0] led_dec(input logic [1:0] sp);
        if (sp == SPD_1000) begin
            led_dec = 3'h4;
        end else if (sp == SPD_100) begin
            led_dec = 3'h2;
        end else begin
            led_dec = 3'h1;
        end
    endfunction : led_dec

    function automatic logic [31:0] stat_word(input plm_st_t v);
        stat_word = 32'h0;
        stat_word[SB_LINK] = v.link;
        stat_word[SB_AN_DONE] = v.an_done;
        stat_word[SB_FB] = v.fbf;
        stat_word[SB_SPD +: 2] = v.an_en ? v.spd : v.fspd;
        stat_word[SB_XA] = v.mdi.xa;
        stat_word[SB_XB] = v.mdi.xb;
        stat_word[SB_POL] = v.mdi.pol[0] & v.link;
        stat_word[SB_POL + 1] = v.mdi.pol[1] & v.an_done;
        stat_word[SB_POL + 2] = v.mdi.pol[2] & v.link;
        stat_word[SB_POL + 3] = v.mdi.pol[3] & v.link;
        stat_word[SB_ADV +: 3] = v.adv;
    endfunction : stat_word

    function automatic logic [31:0] ctrl_word(input plm_st_t v);
        ctrl_word = 32'h0;
        ctrl_word[CB_AN_EN] = v.an_en;
        ctrl_word[CB_LB] = v.lb;
        ctrl_word[CB_FB_EN] = v.fb_en;
        ctrl_word[CB_CAP +: 3] = v.cap;
        ctrl_word[CB_FSPD +: 2] = v.fspd;
    endfunction : ctrl_word

    always_comb begin
        n = s;
        n.anrs = 1'b0;
        n.nlp = 1'b0;
        n.tick = 1'b0;
        n.rsp = '0;
        hit = 1'b0;
        sw = 1'b0;
        spd_eff = s.an_en ? s.spd : s.fspd;
        acc = APB_I.psel && APB_I.penable && !s.rsp.pready;
        inc48 = {EV_I.tx_pkt, EV_I.crc_err, EV_I.good_pkt};
        inc16 = {EV_I.err_idle, EV_I.err_data};
        fail = (s.st != ST_UP) && (s.try_ms >= AN_TRY_MS);
        stat_now = stat_word(s);
        // Millisecond enable
        if (s.div == DIV_W'(CYC_PER_MS - 1)) begin
            n.div = '0;
            n.tick = 1'b1;
        end else begin
            n.div = s.div + 17'h00001;
        end
        // Pulse interval and silence timers
        if (EV_I.nlp && ((s.gap >= NLP_MIN_MS) || (s.st != ST_UP))) begin
            n.gap = '0;
        end else if (s.tick) begin
            n.gap = ms_inc(s.gap);
        end
        if (EV_I.nlp) begin
            n.silent = '0;
        end else if (s.tick) begin
            n.silent = ms_inc(s.silent);
        end
        if (s.tick) begin
            n.try_ms = ms_inc(s.try_ms);
        end
        // Link state machine
        case (s.st)
            ST_NEG: begin
                if (!s.an_en) begin
                    n.st = ST_WAIT;
                    n.try_ms = '0;
                end else if (AN_DONE_I) begin
                    n.an_done = 1'b1;
                    n.spd = AN_SPD_I;
                    n.st = ST_WAIT;
                    n.try_ms = '0;
                end
            end
            ST_WAIT: begin
                if ((spd_eff == SPD_10) ? EV_I.nlp : EV_I.idle_ok) begin
                    n.st = ST_UP;
                    n.link = 1'b1;
                    n.fails = '0;
                    n.gap = '0;
                end
            end
            ST_UP: begin
                if ((spd_eff == SPD_10) ? (s.gap > NLP_MAX_MS) : !EV_I.idle_ok) begin
                    n.st = ST_NEG;
                    n.link = 1'b0;
                    n.an_done = 1'b0;
                    n.adv = s.cap;
                    n.fails = '0;
                    n.anrs = s.an_en;
                    n.try_ms = '0;
                end
            end
            default: begin
                n.st = ST_NEG;
            end
        endcase
        // Attempt timeout and fallback step
        if (fail && (n.st != ST_UP)) begin
            n.st = ST_NEG;
            n.an_done = 1'b0;
            n.try_ms = '0;
            n.anrs = s.an_en;
            if (s.fails >= 3'(AN_TRIES - 1)) begin
                n.fails = '0;
                if (s.fb_en) begin
                    n.adv = adv_step(s.adv);
                end
            end else begin
                n.fails = s.fails + 3'h1;
            end
        end
        if ((s.adv != s.cap) && (s.silent >= FB_SILENT_MS)) begin
            n.adv = s.cap;
            n.fails = '0;
        end
        if (!s.fb_en) begin
            n.adv = s.cap;
        end
        n.fbf = s.adv != s.cap;
        // Link pulse transmit timer
        if ((spd_eff == SPD_10) && (s.st != ST_NEG) && !s.lb) begin
            if (s.tick) begin
                if (s.ntx >= NLP_TX_MS - 12'h001) begin
                    n.ntx = '0;
                    n.nlp = 1'b1;
                end else begin
                    n.ntx = ms_inc(s.ntx);
                end
            end
        end else begin
            n.ntx = '0;
        end
        // Line side and loopback
        n.flp = s.an_en && (s.st == ST_NEG) && !s.lb;
        n.mlt3 = !s.an_en && (s.fspd == SPD_100) && !s.link && !s.lb;
        n.txen = s.link && !s.lb;
        n.txpwr = !s.lb;
        n.ltx = (s.lb || !s.link) ? '0 : SCR_OUT_I;
        n.dsc = s.lb ? SCR_OUT_I : LINE_RX_I;
        n.led = s.link ? led_dec(spd_eff) : 3'h0;
        n.mdi = MDI_I;
        // Statistics; wrap is the natural modulo of the adder
        for (int g = 0; g < 3; g++) begin
            if (inc48[g]) begin
                n.c48[g] = s.c48[g] + 48'h1;
            end
        end
        for (int g = 0; g < 2; g++) begin
            if (inc16[g]) begin
                n.c16[g] = s.c16[g] + 16'h1;
            end
        end
        // APB slave, one wait state
        if (acc) begin
            n.rsp.pready = 1'b1;
            if (APB_I.paddr == OFS_CTRL) begin
                n.rsp.prdata = ctrl_word(s);
                if (APB_I.pwrite) begin
                    n.an_en = APB_I.pwdata[CB_AN_EN];
                    n.lb = APB_I.pwdata[CB_LB];
                    n.fb_en = APB_I.pwdata[CB_FB_EN];
                    n.cap = APB_I.pwdata[CB_CAP +: 3];
                    n.fspd = APB_I.pwdata[CB_FSPD +: 2];
                    sw = APB_I.pwdata[CB_SWRST];
                end
            end else if (APB_I.paddr == OFS_STAT) begin
                n.rsp.prdata = stat_word(s);
            end else begin
                for (int g = 0; g < 3; g++) begin
                    if (APB_I.paddr == OFS_C48[g]) begin
                        hit = 1'b1;
                        n.rsp.prdata = {16'h0, s.c48[g][15:0]};
                        if (!APB_I.pwrite) begin
                            n.sn[g] = s.c48[g][47:16];
                        end
                    end else if (APB_I.paddr == OFS_C48[g] + OFS_MID) begin
                        hit = 1'b1;
                        n.rsp.prdata = {16'h0, s.sn[g][15:0]};
                    end else if (APB_I.paddr == OFS_C48[g] + OFS_HIGH) begin
                        hit = 1'b1;
                        n.rsp.prdata = {16'h0, s.sn[g][31:16]};
                        if (!APB_I.pwrite) begin
                            n.c48[g] = {47'h0, inc48[g]};
                        end
                    end
                end
                for (int g = 0; g < 2; g++) begin
                    if (APB_I.paddr == OFS_C16[g]) begin
                        hit = 1'b1;
                        n.rsp.prdata = {16'h0, s.c16[g]};
                    end
                end
                n.rsp.pslverr = !hit;
            end
        end
        // Software reset
        if (sw) begin
            n.c48 = '0;
            n.sn = '0;
            n.c16 = '0;
            n.fbf = 1'b0;
            n.adv = n.cap;
            n.fails = '0;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_B_I) begin
            s <= '0;
            s.st <= ST_NEG;
            s.an_en <= RST_AN_EN;
            s.lb <= RST_LB;
            s.fb_en <= RST_FB_EN;
            s.cap <= RST_CAP;
            s.adv <= RST_CAP;
            s.fspd <= RST_FSPD;
        end else begin
            s <= n;
        end
    end

    assign APB_O = s.rsp;
    assign LINE_TX_O = s.ltx;
    assign DESCR_IN_O = s.dsc;
    assign TX_PWR_EN_O = s.txpwr;
    assign TX_EN_O = s.txen;
    assign LINK_UP_O = s.link;
    assign NLP_TX_O = s.nlp;
    assign FLP_TX_O = s.flp;
    assign MLT3_TX_O = s.mlt3;
    assign AN_RESTART_O = s.anrs;
    assign ADV_O = s.adv;
    assign LED_O = s.led;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_B_I);

    AST_LB_QUIET: assert property (s.lb |=> !TX_PWR_EN_O && (LINE_TX_O == '0))
        else $error("Line active during loopback");
    AST_LB_PATH: assert property (s.lb |=> DESCR_IN_O == $past(SCR_OUT_I))
        else $error("Loopback path broken");
    AST_IDLE_DROP: assert property ((s.st == ST_UP) && (spd_eff != SPD_10)
        && !EV_I.idle_ok |=> !LINK_UP_O ##1 !TX_EN_O)
        else $error("Link kept without idles");
    AST_NLP_DROP: assert property ((s.st == ST_UP) && (spd_eff == SPD_10)
        && (s.gap > NLP_MAX_MS) |=> !LINK_UP_O)
        else $error("Link kept without pulses");
    AST_LO_LATCH: assert property (acc && !APB_I.pwrite && (APB_I.paddr == OFS_RXG)
        |=> (s.sn[0] == $past(s.c48[0][47:16])) && APB_O.pready)
        else $error("Low read did not snapshot");
    AST_HI_CLR: assert property (acc && !APB_I.pwrite
        && (APB_I.paddr == OFS_RXG + OFS_HIGH) |=> s.c48[0] <= 48'h1)
        else $error("High read did not clear");
    AST_FB_OFF: assert property (!s.fb_en |=> ADV_O == $past(s.cap))
        else $error("Fallback active while disabled");
    AST_FB_FLAG: assert property ((s.adv != s.cap) && !sw |=> stat_now[SB_FB])
        else $error("Fallback flag missing");
    AST_POL_GATE: assert property (!s.link |-> (stat_now[SB_POL +: 4] & 4'hD) == 4'h0)
        else $error("Polarity shown without link");
    AST_ERR16: assert property (EV_I.err_data && !sw |=> s.c16[0] == $past(s.c16[0]) + 16'h1)
        else $error("Data error not counted");
    AST_TX_STOP: assert property (!LINK_UP_O |=> !TX_EN_O)
        else $error("Transmit enabled without link");
    AST_LED_OFF: assert property (!LINK_UP_O |=> LED_O == 3'h0)
        else $error("Speed indicator lit without link");
    AST_LB_SILENT: assert property (s.lb |=> !FLP_TX_O && !MLT3_TX_O && !NLP_TX_O)
        else $error("Line signalling during loopback");
    AST_PWR_BACK: assert property ($fell(s.lb) |=> TX_PWR_EN_O)
        else $error("Transmitters off after loopback");
    AST_SW_CLR: assert property (sw |=> (s.c48 == '0) && (s.sn == '0) && (s.c16 == '0))
        else $error("Software reset left counts");
    AST_FLAG_CLR: assert property (sw |=> !stat_now[SB_FB])
        else $error("Software reset left fallback flag");
    AST_TX_COUNT: assert property (EV_I.tx_pkt && !sw
        && !(acc && !APB_I.pwrite && (APB_I.paddr == OFS_TXP + OFS_HIGH))
        |=> s.c48[2] == $past(s.c48[2]) + 48'h1)
        else $error("Transmit packet not counted");
endmodule : plm_top

// *** plm_pkg.sv ***
/*
 Package of the link monitor and statistics block: register map, field
 positions, reset values, timing constants and the carrier types.
 Assumes a 100 MHz system clock; all times are counted in 1 ms ticks.
*/
package plm_pkg;
    // Timing
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;
    localparam int DIV_W = 17;
    localparam int MS_W = 12;
    localparam logic [11:0] NLP_TX_MS = 12'h010;
    localparam logic [11:0] NLP_MIN_MS = 12'h008;
    localparam logic [11:0] NLP_MAX_MS = 12'h018;
    localparam logic [11:0] FB_SILENT_MS = 12'h7D0;
    localparam logic [11:0] AN_TRY_MS = 12'h3E8;
    localparam int AN_TRIES = 3;
    localparam int SYM_W = 4;
    localparam int ADDR_W = 8;
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_RXG = 8'h08;
    localparam logic [7:0] OFS_CRC = 8'h14;
    localparam logic [7:0] OFS_TXP = 8'h20;
    localparam logic [7:0] OFS_RED = 8'h2C;
    localparam logic [7:0] OFS_REI = 8'h30;
    localparam logic [7:0] OFS_MID = 8'h04;
    localparam logic [7:0] OFS_HIGH = 8'h08;
    localparam logic [2:0][7:0] OFS_C48 = {OFS_TXP, OFS_CRC, OFS_RXG};
    localparam logic [1:0][7:0] OFS_C16 = {OFS_REI, OFS_RED};
    // Control fields and reset values
    localparam int CB_AN_EN = 0;
    localparam int CB_LB = 1;
    localparam int CB_FB_EN = 2;
    localparam int CB_SWRST = 3;
    localparam int CB_CAP = 4;
    localparam int CB_FSPD = 7;
    localparam logic RST_AN_EN = 1'b1;
    localparam logic RST_LB = 1'b0;
    localparam logic RST_FB_EN = 1'b1;
    localparam logic [2:0] RST_CAP = 3'h7;
    localparam logic [1:0] RST_FSPD = 2'h1;
    // Status fields
    localparam int SB_LINK = 0;
    localparam int SB_AN_DONE = 1;
    localparam int SB_FB = 2;
    localparam int SB_SPD = 3;
    localparam int SB_XA = 5;
    localparam int SB_XB = 6;
    localparam int SB_POL = 7;
    localparam int SB_ADV = 11;
    // Speed codes; advertisement bits are {1000, 100, 10}
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;

    typedef enum logic [1:0] {ST_NEG, ST_WAIT, ST_UP} plm_lst_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } plm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } plm_apb_rsp_t;

    typedef struct packed {
        logic nlp;
        logic idle_ok;
        logic good_pkt;
        logic crc_err;
        logic err_data;
        logic err_idle;
        logic tx_pkt;
    } plm_ev_t;

    typedef struct packed {
        logic xa;
        logic xb;
        logic [3:0] pol;
    } plm_mdi_t;

    typedef struct packed {
        plm_lst_t st;
        logic link;
        logic an_done;
        logic [1:0] spd;
        logic an_en;
        logic lb;
        logic fb_en;
        logic [2:0] cap;
        logic [1:0] fspd;
        logic [2:0] adv;
        logic [2:0] fails;
        logic fbf;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [MS_W-1:0] gap;
        logic [MS_W-1:0] silent;
        logic [MS_W-1:0] try_ms;
        logic [MS_W-1:0] ntx;
        logic nlp;
        logic flp;
        logic mlt3;
        logic anrs;
        logic txen;
        logic txpwr;
        logic [SYM_W-1:0] ltx;
        logic [SYM_W-1:0] dsc;
        logic [2:0] led;
        plm_mdi_t mdi;
        logic [2:0][47:0] c48;
        logic [2:0][31:0] sn;
        logic [1:0][15:0] c16;
        plm_apb_rsp_t rsp;
    } plm_st_t;
endpackage : plm_pkg

// *** plm_partner.sv ***
/*
 Remote link partner model: answers negotiation, sends link pulses and idles.
 Assumes the block's clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module plm_partner (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic flp_i,
    input wire logic answer_i,
    input wire logic [1:0] spd_i,
    input wire logic nlp_en_i,
    input wire logic idle_en_i,
    input wire logic [11:0] gap_i,
    output logic an_done_o,
    output logic [1:0] an_spd_o,
    output logic nlp_o,
    output logic idle_ok_o
);
    logic [11:0] cnt_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_ff <= 12'h000;
            an_done_o <= 1'b0;
            nlp_o <= 1'b0;
            idle_ok_o <= 1'b0;
        end else begin
            an_done_o <= flp_i & answer_i & ~an_done_o;
            idle_ok_o <= idle_en_i;
            nlp_o <= nlp_en_i && (cnt_ff == gap_i - 12'h001);
            cnt_ff <= (nlp_en_i && cnt_ff != gap_i - 12'h001) ? cnt_ff + 12'h001 : 12'h000;
        end
    end

    // Speed only qualifies the completion pulse; outside it the lines change
    assign an_spd_o = an_done_o ? spd_i : ~spd_i;
endmodule : plm_partner

// *** plm_top_tb_top.sv ***
/*
 Self-checking bench of the link monitor: APB register tasks, link partner,
 counter events. Assumes a 100 MHz clock and a shortened millisecond tick.
*/
`timescale 1ns/10ps
module plm_top_tb_top;
    import plm_pkg::*;
    localparam int CYC = 10;
    localparam logic [31:0] CTRL_DEF = 32'h000000F5;
    localparam int B48[3] = '{4, 3, 0};
    logic clk, rst_b, an_done, p_nlp, p_idle, answer, nlp_en, idle_en, rd_err;
    logic tx_pwr, tx_en, link_up, nlp_tx, flp_tx, mlt3_tx, an_rs, rs_seen;
    plm_apb_req_t apb_req;
    plm_apb_rsp_t apb_rsp;
    plm_ev_t ev;
    plm_mdi_t mdi;
    logic [4:0] cnt_ev;
    logic [SYM_W-1:0] scr_out, line_rx, line_tx, descr_in;
    logic [2:0] adv, led, adv_ref;
    logic [1:0] an_spd, spd;
    logic [31:0] rd_data;
    int err_count, compares, n, k;

    assign ev = {p_nlp, p_idle, cnt_ev};

    plm_top #(.CYC_PER_MS(CYC), .AN_TRIES(1)) dut (
        .CLK_SYS_I(clk), .RST_B_I(rst_b), .APB_I(apb_req), .APB_O(apb_rsp),
        .EV_I(ev), .AN_DONE_I(an_done), .AN_SPD_I(an_spd), .MDI_I(mdi),
        .SCR_OUT_I(scr_out), .LINE_RX_I(line_rx), .LINE_TX_O(line_tx),
        .DESCR_IN_O(descr_in), .TX_PWR_EN_O(tx_pwr), .TX_EN_O(tx_en),
        .LINK_UP_O(link_up), .NLP_TX_O(nlp_tx), .FLP_TX_O(flp_tx),
        .MLT3_TX_O(mlt3_tx), .AN_RESTART_O(an_rs), .ADV_O(adv), .LED_O(led));

    plm_partner partner (
        .clk_i(clk), .rst_b_i(rst_b), .flp_i(flp_tx), .answer_i(answer),
        .spd_i(spd), .nlp_en_i(nlp_en), .idle_en_i(idle_en), .gap_i(12'(20 * CYC)),
        .an_done_o(an_done), .an_spd_o(an_spd), .nlp_o(p_nlp), .idle_ok_o(p_idle));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Sticky record of any negotiation restart pulse
    always @(posedge clk) rs_seen <= rst_b ? (rs_seen | an_rs) : 1'b0;

    task automatic summarize();
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        int t;
        t = 0;
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (apb_rsp.pready !== 1'b1 && t < 20);
        r = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        chk("pready", 32'(apb_rsp.pready), 32'h1);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0, rd_data, rd_err);
        chk(nm, rd_data, exp);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd_data, rd_err);
    endtask : wr

    task automatic pulse(input int b, input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            cnt_ev[b] <= 1'b1;
            @(posedge clk);
            cnt_ev[b] <= 1'b0;
        end
    endtask : pulse

    function automatic logic cond(input int w);
        case (w)
            0: return link_up === 1'b1;
            1: return link_up === 1'b0;
            2: return nlp_tx === 1'b1;
            default: return adv !== adv_ref;
        endcase
    endfunction : cond

    task automatic wait_for(input int w, input int lim);
        n = 0;
        while (cond(w) !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_for

    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        summarize();
    end

    initial begin
        err_count = 0;
        compares = 0;
        rst_b = 1'b0;
        apb_req = '0;
        cnt_ev = 5'h00;
        mdi = '{xa: 1'b1, xb: 1'b0, pol: 4'hF};
        scr_out = 4'hA;
        line_rx = 4'h5;
        answer = 1'b0;
        spd = SPD_100;
        nlp_en = 1'b0;
        idle_en = 1'b0;
        adv_ref = 3'h7;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("adv reset", 32'(adv), 32'h7);
        rd(OFS_CTRL, CTRL_DEF, "ctrl reset");
        rd(OFS_STAT, 32'h00003820, "stat reset");
        apb(1'b0, 8'h40, 32'h0, rd_data, rd_err);
        chk("unmapped err", 32'(rd_err), 32'h1);
        chk("unmapped data", rd_data, 32'h0);
        for (k = 0; k < 3; k++) begin
            pulse(B48[k], k + 3);
            rd(OFS_C48[k], 32'(k + 3), "c48 low");
            pulse(B48[k], 2);
            rd(OFS_C48[k] + OFS_MID, 32'h0, "c48 mid");
            rd(OFS_C48[k] + OFS_HIGH, 32'h0, "c48 high");
            rd(OFS_C48[k], 32'h0, "c48 cleared");
        end
        pulse(2, 4);
        pulse(1, 6);
        rd(OFS_RED, 32'h4, "err data");
        rd(OFS_REI, 32'h6, "err idle");
        rd(OFS_RED, 32'h4, "err data again");
        chk("line path", 32'(descr_in), 32'h5);
        wr(OFS_CTRL, CTRL_DEF | 32'h2);
        repeat (2) @(posedge clk);
        chk("loop descr", 32'(descr_in), 32'hA);
        chk("loop line", 32'(line_tx), 32'h0);
        chk("loop power", 32'(tx_pwr), 32'h0);
        wr(OFS_CTRL, CTRL_DEF);
        repeat (2) @(posedge clk);
        chk("power back", 32'(tx_pwr), 32'h1);
        answer <= 1'b1;
        idle_en <= 1'b1;
        wait_for(0, 2000);
        chk("link 100", 32'(link_up), 32'h1);
        chk("no restart", 32'(rs_seen), 32'h0);
        repeat (2) @(posedge clk);
        chk("tx en", 32'(tx_en), 32'h1);
        chk("led 100", 32'(led), 32'h2);
        chk("line tx", 32'(line_tx), 32'hA);
        apb(1'b0, OFS_STAT, 32'h0, rd_data, rd_err);
        chk("stat mdi", rd_data & 32'h000007E1, 32'h000007A1);
        chk("stat spd", (rd_data >> 3) & 32'h3, 32'h1);
        answer <= 1'b0;
        idle_en <= 1'b0;
        wait_for(1, 4);
        chk("drop 100", 32'(link_up), 32'h0);
        repeat (2) @(posedge clk);
        chk("tx stop", 32'(tx_en), 32'h0);
        chk("an restart", 32'(rs_seen), 32'h1);
        chk("flp", 32'(flp_tx), 32'h1);
        spd <= SPD_10;
        answer <= 1'b1;
        nlp_en <= 1'b1;
        wait_for(0, 40 * CYC);
        chk("link 10", 32'(link_up), 32'h1);
        answer <= 1'b0;
        repeat (2) @(posedge clk);
        chk("led 10", 32'(led), 32'h1);
        wait_for(2, 20 * CYC);
        @(posedge clk);
        wait_for(2, 20 * CYC);
        chk("nlp period", 32'(n + 1), 32'(16 * CYC));
        repeat (100 * CYC) @(posedge clk);
        chk("link held", 32'(link_up), 32'h1);
        nlp_en <= 1'b0;
        wait_for(1, 30 * CYC);
        chk("drop 10", 32'(link_up), 32'h0);
        repeat (3) @(posedge clk);
        chk("flp again", 32'(flp_tx), 32'h1);
        wr(OFS_CTRL, 32'h000000F4);
        repeat (4) @(posedge clk);
        chk("mlt3", 32'(mlt3_tx), 32'h1);
        wr(OFS_CTRL, 32'h00000074);
        wait_for(2, 20 * CYC);
        chk("forced nlp", 32'(nlp_tx), 32'h1);
        wr(OFS_CTRL, CTRL_DEF);
        wait_for(3, 12000);
        chk("step one", 32'(adv), 32'h3);
        adv_ref = 3'h3;
        nlp_en <= 1'b1;
        wait_for(3, 12000);
        chk("step two", 32'(adv), 32'h1);
        repeat (2) @(posedge clk);
        apb(1'b0, OFS_STAT, 32'h0, rd_data, rd_err);
        chk("fb flag", (rd_data >> 2) & 32'h1, 32'h1);
        pulse(0, 3);
        wr(OFS_CTRL, CTRL_DEF | 32'h8);
        repeat (2) @(posedge clk);
        chk("adv swrst", 32'(adv), 32'h7);
        apb(1'b0, OFS_STAT, 32'h0, rd_data, rd_err);
        chk("fb flag clr", (rd_data >> 2) & 32'h1, 32'h0);
        rd(OFS_TXP, 32'h0, "tx swrst");
        wr(OFS_CTRL, 32'h000000F1);
        repeat (12000) @(posedge clk);
        chk("fb off", 32'(adv), 32'h7);
        summarize();
    end
endmodule : plm_top_tb_top
